// ### rtl/htc_pkg.sv
// Purpose: Shared constants and types of the host transport command decoder.
// Assumes: 16-bit command and payload words, MSB first on the serial port.
// Notes:   Command codes are compared against the upper bits of the command word.
`default_nettype none

package htc_pkg;

	localparam int          WORD_W             = 16;
	localparam int          PAGE_W             = 8;
	localparam int          LOC_W              = 8;
	localparam int          ADDR_W             = 30;
	localparam int          CL_BASE_W          = 22;
	localparam int          CRC_W              = 32;
	localparam int          OPT_W              = 8;
	localparam int          OPT_ALERT_BIT      = 4;
	localparam int          OPT_WAKE_BIT       = 7;
	localparam logic [3:0]  LINK_LAST_BIT      = 4'hF;
	localparam logic [6:0]  DIRECT_LAST_OFFSET = 7'h76;
	localparam logic [6:0]  CMD_MBX_START_HI   = 7'h7C;
	localparam logic [6:0]  CMD_MBX_CONT_HI    = 7'h7D;
	localparam logic [7:0]  CMD_CONFIG_HI      = 8'hFD;
	localparam logic [7:0]  CMD_PAGE_HI        = 8'hFE;
	localparam logic [7:0]  CMD_CL_LO          = 8'h80;
	localparam logic [15:0] CMD_NOP            = 16'hFFFF;
	localparam logic [7:0]  OPT_RESET          = 8'h00;
	localparam logic [7:0]  PAGE_RESET         = 8'h00;
	localparam logic [31:0] CRC_RESET          = 32'h0000_0000;
	localparam logic [31:0] CRC_POLY           = 32'h04C1_1DB7;

	typedef enum {
		ST_CMD,
		ST_WR,
		ST_RD
	} htc_state_t;

endpackage : htc_pkg

`default_nettype wire

// ### rtl/htc_serial_port.sv
// Purpose: Link-clock side of the serial slave port: word assembly and read shift-out.
// Assumes: Clock idles low, data sampled on rising edge, changed on falling edge.
// Notes:   The core holds tx_word_i stable for a whole word time after each word event.
`default_nettype none

module htc_serial_port (
	input  wire logic                      sck_i,
	input  wire logic                      cs_n_i,
	input  wire logic                      sdi_i,
	input  wire logic [htc_pkg::WORD_W-1:0] tx_word_i,
	output logic                           sdo_o,
	output logic      [htc_pkg::WORD_W-1:0] rx_word_o,
	output logic                           rx_tgl_o
);
	import htc_pkg::*;

	logic [3:0]        bit_cnt;
	logic [WORD_W-2:0] shift_in;
	logic [WORD_W-1:0] tx_sr;

	// The link clock stands still between frames, so the frame select clears the bit position.
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt <= 4'h0;
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			shift_in <= '0;
		end else begin
			shift_in <= {shift_in[WORD_W-3:0], sdi_i};
		end
	end

	// Each completed word flips the toggle; the core sees it as one event.
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rx_word_o <= '0;
			rx_tgl_o  <= 1'b0;
		end else if (bit_cnt == LINK_LAST_BIT) begin
			rx_word_o <= {shift_in, sdi_i};
			rx_tgl_o  <= ~rx_tgl_o;
		end
	end

	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			tx_sr <= '0;
		end else if (bit_cnt == 4'h0) begin
			tx_sr <= tx_word_i;
		end else begin
			tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
		end
	end

	assign sdo_o = tx_sr[WORD_W-1];

endmodule : htc_serial_port

`default_nettype wire

// ### rtl/htc_transport.sv
// Purpose: Transport layer of the host control interface: command decode and word moves.
// Assumes: Internal bus read data is valid in the cycle bus_rd_o is high.
// Notes:   Read data must reach the link before the next falling link edge after a word.
`default_nettype none

module htc_transport (
	input  wire logic                          clk_i,
	input  wire logic                          srst_i,
	input  wire logic                          ce_i,
	input  wire logic                          sck_i,
	input  wire logic                          cs_n_i,
	input  wire logic                          sdi_i,
	output logic                               sdo_o,
	output logic                               bus_wr_o,
	output logic                               bus_rd_o,
	output logic                               bus_direct_o,
	output logic                               bus_cl_o,
	output logic      [htc_pkg::PAGE_W-1:0]    bus_page_o,
	output logic      [htc_pkg::LOC_W-1:0]     bus_loc_o,
	output logic      [htc_pkg::ADDR_W-1:0]    bus_addr_o,
	output logic      [htc_pkg::WORD_W-1:0]    bus_wdata_o,
	input  wire logic [htc_pkg::WORD_W-1:0]    bus_rdata_i,
	input  wire logic [htc_pkg::CL_BASE_W-1:0] cl_base_i,
	input  wire logic [htc_pkg::CRC_W-1:0]     crc_seed_i,
	input  wire logic                          crc_seed_load_i,
	output logic      [htc_pkg::CRC_W-1:0]     crc_o,
	input  wire logic                          dsp_wake_ack_i,
	output logic                               dsp_wake_request_o,
	input  wire logic                          alert_i,
	output logic                               alert_n_o,
	output logic                               alert_oe_o
);
	import htc_pkg::*;

	htc_state_t        st;
	htc_state_t        next_st;
	logic [WORD_W-1:0] link_word;
	logic              link_tgl;
	logic [WORD_W-1:0] tx_word;
	logic              cs_s1;
	logic              cs_s2;
	logic              tgl_s1;
	logic              tgl_s2;
	logic              tgl_s3;
	logic              ev;
	logic [PAGE_W-1:0] page_q;
	logic              cl_sel;
	logic [OPT_W-1:0]  opt_q;
	logic [LOC_W-1:0]  loc_q;
	logic [LOC_W-1:0]  cnt_q;
	logic [LOC_W-1:0]  mbx_pos;
	logic              cur_direct;
	logic              cur_cl;
	logic              cur_mbx;
	logic              cmd_paged;
	logic              cmd_direct;
	logic              cmd_mbx_start;
	logic              cmd_mbx_cont;
	logic              cmd_config;
	logic              cmd_page;
	logic              cmd_cl;
	logic              cmd_access;
	logic              cmd_reserved;
	logic              cmd_rw;
	logic [LOC_W-1:0]  cmd_loc;
	logic [LOC_W-1:0]  cmd_len;
	logic              go_rd;
	logic              go_wr;
	logic [LOC_W-1:0]  go_loc;
	logic              go_direct;
	logic              go_cl;
	logic [ADDR_W-1:0] go_addr;
	logic              at_cmd;

	htc_serial_port u_link (
		.sck_i     (sck_i),
		.cs_n_i    (cs_n_i),
		.sdi_i     (sdi_i),
		.tx_word_i (tx_word),
		.sdo_o     (sdo_o),
		.rx_word_o (link_word),
		.rx_tgl_o  (link_tgl)
	);

	// Two-stage synchronisers; the word itself is held stable by the link for a word time.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else if (ce_i) begin
			cs_s1  <= cs_n_i;
			cs_s2  <= cs_s1;
			tgl_s1 <= link_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	assign ev = (tgl_s2 ^ tgl_s3) && !cs_s2;
	// Command decode. Every non-offset command lives in the top direct codes.
	assign cmd_paged     = !link_word[15];
	assign cmd_direct    = link_word[15] && (link_word[14:8] <= DIRECT_LAST_OFFSET)
	                       && (link_word[6:4] == 3'h0);
	assign cmd_mbx_start = link_word[15:9] == CMD_MBX_START_HI;
	assign cmd_mbx_cont  = link_word[15:9] == CMD_MBX_CONT_HI;
	assign cmd_config    = link_word[15:8] == CMD_CONFIG_HI;
	assign cmd_page      = (link_word[15:8] == CMD_PAGE_HI) && (link_word[7:4] == 4'h0);
	assign cmd_cl        = link_word == {CMD_PAGE_HI, CMD_CL_LO};
	assign cmd_access    = cmd_paged || cmd_direct || cmd_mbx_start || cmd_mbx_cont;
	assign cmd_reserved  = !(cmd_access || cmd_config || cmd_page || cmd_cl);
	assign at_cmd        = ev && (st == ST_CMD);

	always_comb begin
		cmd_rw  = (cmd_mbx_start || cmd_mbx_cont) ? link_word[8] : link_word[7];
		cmd_loc = {1'b0, link_word[14:8]};
		cmd_len = {1'b0, link_word[6:0]};
		if (cmd_direct) begin
			cmd_len = {4'h0, link_word[3:0]};
		end else if (cmd_mbx_start) begin
			cmd_loc = '0;
			cmd_len = link_word[7:0];
		end else if (cmd_mbx_cont) begin
			cmd_loc = mbx_pos;
			cmd_len = link_word[7:0];
		end
	end

	always_comb begin
		next_st   = st;
		go_rd     = 1'b0;
		go_wr     = 1'b0;
		go_loc    = loc_q + 8'h01;
		go_direct = cur_direct;
		go_cl     = cur_cl;
		case (st)
			ST_CMD: begin
				go_loc    = cmd_loc;
				go_direct = cmd_direct;
				go_cl     = cmd_paged && cl_sel;
				if (ev && cmd_access) begin
					next_st = cmd_rw ? ST_WR : ST_RD;
					go_rd   = !cmd_rw;
				end
			end
			ST_WR: begin
				go_loc = loc_q;
				if (ev) begin
					go_wr = 1'b1;
					if (cnt_q == 8'h00) begin
						next_st = ST_CMD;
					end
				end
			end
			ST_RD: begin
				if (ev) begin
					if (cnt_q == 8'h00) begin
						next_st = ST_CMD;
					end else begin
						go_rd = 1'b1;
					end
				end
			end
			default: begin
				next_st = ST_CMD;
			end
		endcase
	end

	// Code-load page maps to a byte address; others use the page (page 0 for direct) and location.
	assign go_addr = go_cl ? ({cl_base_i, 8'h00} + {22'h0, go_loc[6:0], 1'b0})
	                       : {14'h0, (go_direct ? PAGE_RESET : page_q), go_loc};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= ST_CMD;
		end else if (ce_i) begin
			st <= cs_s2 ? ST_CMD : next_st;
		end
	end

	// Access bookkeeping; loc_q names the location last read, or during a write the next location to write.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			loc_q      <= '0;
			cnt_q      <= '0;
			cur_direct <= 1'b0;
			cur_cl     <= 1'b0;
			cur_mbx    <= 1'b0;
		end else if (ce_i) begin
			if (at_cmd && cmd_access) begin
				loc_q      <= cmd_loc;
				cnt_q      <= cmd_len;
				cur_direct <= cmd_direct;
				cur_cl     <= cmd_paged && cl_sel;
				cur_mbx    <= cmd_mbx_start || cmd_mbx_cont;
			end else if (ev && (st != ST_CMD) && (cnt_q != 8'h00)) begin
				loc_q <= loc_q + 8'h01;
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

	// Only mailbox accesses move the continuation point, so offset accesses may interleave.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mbx_pos <= '0;
		end else if (ce_i) begin
			if (ev && (st != ST_CMD) && (cnt_q == 8'h00) && cur_mbx && !cs_s2) begin
				mbx_pos <= loc_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			page_q <= PAGE_RESET;
			cl_sel <= 1'b0;
		end else if (ce_i) begin
			if (at_cmd && cmd_page) begin
				page_q <= {4'h0, link_word[3:0]};
				cl_sel <= 1'b0;
			end else if (at_cmd && cmd_cl) begin
				cl_sel <= 1'b1;
			end
		end
	end

	// A configure write in the same cycle as the DSP response keeps the new value.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			opt_q <= OPT_RESET;
		end else if (ce_i) begin
			if (at_cmd && cmd_config) begin
				opt_q <= link_word[7:0];
			end else if (dsp_wake_ack_i) begin
				opt_q[OPT_WAKE_BIT] <= 1'b0;
			end
		end
	end
	assign dsp_wake_request_o = opt_q[OPT_WAKE_BIT];

	// Open drain only pulls low; push-pull drives both levels.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			alert_oe_o <= 1'b0;
			alert_n_o  <= 1'b0;
		end else if (ce_i) begin
			alert_oe_o <= opt_q[OPT_ALERT_BIT] ? 1'b1 : alert_i;
			alert_n_o  <= opt_q[OPT_ALERT_BIT] ? ~alert_i : 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bus_wr_o     <= 1'b0;
			bus_rd_o     <= 1'b0;
			bus_direct_o <= 1'b0;
			bus_cl_o     <= 1'b0;
			bus_page_o   <= '0;
			bus_loc_o    <= '0;
			bus_addr_o   <= '0;
			bus_wdata_o  <= '0;
		end else if (ce_i) begin
			bus_wr_o <= go_wr && !cs_s2;
			bus_rd_o <= go_rd && !cs_s2;
			if (go_wr || go_rd) begin
				bus_direct_o <= go_direct;
				bus_cl_o     <= go_cl;
				bus_page_o   <= go_direct ? PAGE_RESET : page_q;
				bus_loc_o    <= go_loc;
				bus_addr_o   <= go_addr;
				bus_wdata_o  <= link_word;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_word <= '0;
		end else if (ce_i && bus_rd_o) begin
			tx_word <= bus_rdata_i;
		end
	end

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic [47:0] d);
		logic [CRC_W-1:0] r;
		r = c;
		for (int i = 47; i >= 0; i--) begin
			r = {r[CRC_W-2:0], 1'b0} ^ ((r[CRC_W-1] ^ d[i]) ? CRC_POLY : CRC_RESET);
		end
		return r;
	endfunction : crc_step

	// Address and data both enter the CRC, so a misplaced block shows even with good data.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			crc_o <= CRC_RESET;
		end else if (ce_i) begin
			if (crc_seed_load_i) begin
				crc_o <= crc_seed_i;
			end else if (go_wr && go_cl && !cs_s2) begin
				crc_o <= crc_step(crc_o, {2'b00, go_addr, link_word});
			end
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i || !ce_i);
	page_select_a: assert property (at_cmd && cmd_page |=> page_q == {4'h0, $past(link_word[3:0])} && !cl_sel)
		else $error("select page did not load the page register");
	cl_select_a: assert property (at_cmd && cmd_cl |=> cl_sel && $stable(page_q))
		else $error("code-load page not selected");
	nop_quiet_a: assert property (at_cmd && link_word == CMD_NOP |=> st == ST_CMD && $stable(page_q) && $stable(opt_q))
		else $error("no-operation changed state");
	reserved_quiet_a: assert property (at_cmd && cmd_reserved |=> st == ST_CMD && !bus_wr_o && !bus_rd_o && $stable(cl_sel))
		else $error("reserved command had an effect");
	direct_page_a: assert property (at_cmd && cmd_direct |=> $stable(page_q) && cur_direct && cnt_q < 8'h10)
		else $error("direct access disturbed the page");
	paged_len_a: assert property (at_cmd && cmd_paged |=> cnt_q == {1'b0, $past(link_word[6:0])})
		else $error("paged length not taken");
	mbx_start_a: assert property (at_cmd && cmd_mbx_start |=> loc_q == 8'h00 && cnt_q == $past(link_word[7:0]))
		else $error("mailbox start not at location zero");
	mbx_resume_a: assert property (at_cmd && cmd_mbx_cont |=> loc_q == $past(mbx_pos))
		else $error("mailbox continue did not resume");
	loc_step_a: assert property (ev && st == ST_WR && cnt_q != 8'h00 |=> loc_q == $past(loc_q) + 8'h01)
		else $error("location did not advance by one");
	config_load_a: assert property (at_cmd && cmd_config |=> opt_q == $past(link_word[7:0]) && st == ST_CMD)
		else $error("configure command mishandled");
	wake_clear_a: assert property (dsp_wake_ack_i && !(at_cmd && cmd_config) |=> !dsp_wake_request_o)
		else $error("wake request not cleared after response");
	alert_drive_a: assert property (!opt_q[OPT_ALERT_BIT] |=> !alert_n_o && alert_oe_o == $past(alert_i))
		else $error("open-drain alert drive wrong");
	read_return_a: assert property (bus_rd_o |=> tx_word == $past(bus_rdata_i))
		else $error("read word not handed to the link");
	write_end_c: cover property (ev && st == ST_WR && cnt_q == 8'h00);
	mbx_resume_c: cover property (at_cmd && cmd_mbx_cont && mbx_pos != 8'h00);
	cl_write_c: cover property (bus_wr_o && bus_cl_o);
	read_burst_c: cover property (bus_rd_o ##[1:300] bus_rd_o);

endmodule : htc_transport

`default_nettype wire

// ### verification/htc_host_model.sv
// Purpose: Host-side serial master that frames command and payload words for the transport.
// Assumes: Link clock idles low, runs only inside frames, period 64 ns, data sampled on rising edges.
// Notes:   Released data lines show the inverse of the last bit so a stale value is never mistaken for data.
`default_nettype none

module htc_host_model (
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b1;
	end

	// The odd lead-in keeps the link edges off the core clock grid.
	task automatic frame_begin();
		#13.3;
		cs_n_o = 1'b0;
		#32;
	endtask : frame_begin

	task automatic frame_end();
		#32;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#45;
	endtask : frame_end

	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			#32;
			sck_o = 1'b1;
			r[i] = sdo_i;
			#32;
			sck_o = 1'b0;
		end
	endtask : xfer

endmodule : htc_host_model

`default_nettype wire

// ### verification/htc_transport_test.sv
// Purpose: Self-checking bench for the transport command decoder.
// Assumes: Bus reads answer with a pattern of page and location the bench can predict.
// Notes:   Refused commands are checked by placing a real access behind them in the same frame.
`default_nettype none

module htc_transport_test;
	timeunit 1ns;
	timeprecision 100ps;
	import htc_pkg::*;

	typedef struct packed {
		logic [2:0]  k;
		logic [7:0]  pg;
		logic [7:0]  lc;
		logic [29:0] ad;
		logic [15:0] d;
	} htc_acc_t;

	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        sck, cs_n, sdi, sdo, bus_wr, bus_rd, bus_dir, bus_cl, alert_n, alert_oe, wake;
	logic        seed_ld = 1'b0;
	logic        wake_ack = 1'b0;
	logic        alert = 1'b0;
	logic [7:0]  bus_pg, bus_lc;
	logic [29:0] bus_ad;
	logic [15:0] wdata;
	logic [15:0] rdata = 16'h0000;
	logic [21:0] cl_base = 22'h012345;
	logic [31:0] seed = 32'hFFFF_0000;
	logic [31:0] crc;
	logic [15:0] tx_q[$], rx_q[$];
	htc_acc_t    acc_q[$];
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	htc_host_model i_htc_host_model (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

	htc_transport i_htc_transport (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
		.sdo_o(sdo), .bus_wr_o(bus_wr), .bus_rd_o(bus_rd), .bus_direct_o(bus_dir), .bus_cl_o(bus_cl),
		.bus_page_o(bus_pg), .bus_loc_o(bus_lc), .bus_addr_o(bus_ad), .bus_wdata_o(wdata),
		.bus_rdata_i(rdata), .cl_base_i(cl_base), .crc_seed_i(seed), .crc_seed_load_i(seed_ld),
		.crc_o(crc), .dsp_wake_ack_i(wake_ack), .dsp_wake_request_o(wake), .alert_i(alert),
		.alert_n_o(alert_n), .alert_oe_o(alert_oe));

	function automatic logic [15:0] pat(input logic [7:0] pg, input logic [7:0] lc);
		return {lc, pg} ^ 16'h5AC3;
	endfunction : pat

	function automatic logic [31:0] crc48(input logic [31:0] c, input logic [47:0] m);
		for (int i = 47; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ m[i]) ? CRC_POLY : 32'h0000_0000);
		return c;
	endfunction : crc48

	always #2 clk_i = ~clk_i;

	// Read data is set half a cycle after the location moves, so it is valid at the sampling edge.
	always @(negedge clk_i) begin
		rdata <= pat(bus_pg, bus_lc);
		if (bus_wr || bus_rd)
			acc_q.push_back({bus_wr, bus_dir, bus_cl, bus_pg, bus_lc, bus_ad, bus_wr ? wdata : 16'h0000});
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic frame();
		logic [15:0] r;
		rx_q = {};
		i_htc_host_model.frame_begin();
		foreach (tx_q[j]) begin
			i_htc_host_model.xfer(tx_q[j], r);
			rx_q.push_back(r);
		end
		i_htc_host_model.frame_end();
	endtask : frame

	// Kind is write, direct, code-load; the page is not compared on code-load accesses.
	task automatic take(input logic [2:0] k, input logic [7:0] pg, lc, input logic [15:0] d);
		htc_acc_t    a;
		logic [29:0] ad;
		a = '1;
		ad = k[0] ? {cl_base, 8'h00} + {22'h000000, lc[6:0], 1'b0} : {14'h0000, pg, lc};
		if (acc_q.size() != 0)
			a = acc_q.pop_front();
		chk("access kind and location", 32'({a.k, k[0] ? pg : a.pg, a.lc}), 32'({k, pg, lc}));
		chk("bus address", 32'(a.ad), 32'(ad));
		chk("write data", 32'(a.d), 32'(d));
	endtask : take

	task automatic done(input string nm);
		$display("test %s finished, mismatches so far %0d", nm, n_mismatch);
	endtask : done

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	initial begin
		repeat (5) @(posedge clk_i);
		@(negedge clk_i) srst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		chk("outputs after reset", 32'({wake, alert_oe, bus_wr, bus_rd}), 32'h0);
		chk("crc after reset", crc, CRC_RESET);
		done("reset");

		tx_q = '{16'hFE03, 16'h0581, 16'h1111, 16'h2222};
		frame();
		take(3'b100, 8'h03, 8'h05, 16'h1111);
		take(3'b100, 8'h03, 8'h06, 16'h2222);
		done("paged write");

		tx_q = '{16'h0A02, 16'h0000, 16'hFFFF, 16'h0000};
		frame();
		for (int k = 1; k <= 3; k++) begin
			take(3'b000, 8'h03, 8'(9 + k), 16'h0000);
			chk("read word", 32'(rx_q[k]), 32'(pat(8'h03, 8'(9 + k))));
		end
		done("paged read");

		tx_q = '{16'h9083, 16'h0101, 16'h0202, 16'h0303, 16'h0404, 16'h0080, 16'hABCD, 16'hF680, 16'hC0DE, 16'h908F};
		for (int k = 0; k < 16; k++)
			tx_q.push_back(16'(k));
		frame();
		for (int k = 0; k < 4; k++)
			take(3'b110, 8'h00, 8'(16 + k), {2{8'(k + 1)}});
		take(3'b100, 8'h03, 8'h00, 16'hABCD);
		take(3'b110, 8'h00, 8'h76, 16'hC0DE);
		for (int k = 0; k < 16; k++)
			take(3'b110, 8'h00, 8'(16 + k), 16'(k));
		done("direct page");

		tx_q = '{16'h9093, 16'hF780, 16'hFC00, 16'hFEFF, 16'hFFFF, 16'h0780, 16'h7777};
		frame();
		take(3'b100, 8'h03, 8'h07, 16'h7777);
		chk("no extra access", 32'(acc_q.size()), 32'h0);
		done("refused commands");

		tx_q = '{16'hF902, 16'h0A0A, 16'h0B0B, 16'h0C0C, 16'h2080, 16'h0D0D, 16'hFA01, 16'h0000, 16'h0000};
		tx_q.push_back(16'hF800);
		tx_q.push_back(16'h0000);
		frame();
		for (int k = 0; k < 3; k++)
			take(3'b100, 8'h03, 8'(k), {2{8'(10 + k)}});
		take(3'b100, 8'h03, 8'h20, 16'h0D0D);
		for (int k = 3; k < 5; k++) begin
			take(3'b000, 8'h03, 8'(k), 16'h0000);
			chk("mailbox read word", 32'(rx_q[k + 4]), 32'(pat(8'h03, 8'(k))));
		end
		take(3'b000, 8'h03, 8'h00, 16'h0000);
		done("mailbox");

		@(negedge clk_i) alert = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("open drain asserted", 32'({alert_oe, alert_n}), 32'h2);
		alert = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("open drain released", 32'(alert_oe), 32'h0);
		tx_q = '{16'hFD10};
		frame();
		chk("push pull idle", 32'({alert_oe, alert_n}), 32'h3);
		chk("no payload access", 32'(acc_q.size()), 32'h0);
		tx_q = '{16'hFD90};
		frame();
		chk("wake raised", 32'({wake, alert_oe}), 32'h3);
		@(negedge clk_i) wake_ack = 1'b1;
		repeat (2) @(negedge clk_i);
		wake_ack = 1'b0;
		chk("wake cleared", 32'(wake), 32'h0);
		done("configure");

		@(negedge clk_i) seed_ld = 1'b1;
		@(negedge clk_i) seed_ld = 1'b0;
		chk("crc seed", crc, seed);
		tx_q = '{16'hFE80, 16'h0480, 16'hBEEF, 16'hFE03, 16'h0180, 16'h1234};
		frame();
		take(3'b101, 8'h03, 8'h04, 16'hBEEF);
		take(3'b100, 8'h03, 8'h01, 16'h1234);
		chk("crc after load", crc, crc48(seed, {2'b00, cl_base, 8'h08, 16'hBEEF}));
		done("code load");
		complete_run();
	end

endmodule : htc_transport_test

`default_nettype wire
